/* File: pkg/ptl_defines.vh */
// Register offsets, field positions and reset values of the PHY test,
// loopback and power saving extended registers.
// Assumes extended registers are reached through an index/data port pair.
`ifndef PTL_DEFINES_VH
`define PTL_DEFINES_VH

// Management port offsets
`define PTL_PORT_ADDR       5'h1d
`define PTL_PORT_DATA       5'h1e

// Extended register indexes
`define PTL_IDX_FAST_TEST   6'h10
`define PTL_IDX_TEN_TEST    6'h12
`define PTL_IDX_POWER_SAVE  6'h29

// Fast test register fields
`define PTL_FT_ENABLE       15
`define PTL_FT_JITTER       7
`define PTL_FT_OVERSWING    6
`define PTL_FT_DCD          5
`define PTL_FT_LINE_CODE    4
`define PTL_FT_SCRAMBLER    3
`define PTL_FT_CARRIER_MON  2
`define PTL_FT_FAR_FAULT    1
`define PTL_FT_CODING       0

// Ten test register fields
`define PTL_TT_SEL_HI       5
`define PTL_TT_DEPTH        2

// Ten test pattern codes
`define PTL_PAT_ONES_10M    3'h1
`define PTL_PAT_RANDOM      3'h2
`define PTL_PAT_LINK_PULSE  3'h3
`define PTL_PAT_SINE_5M     3'h4

// Power saving register fields and reset values, and the ten test reserved reset value
`define PTL_PS_STATE        15
`define PTL_PS_AMP100_LO    9
`define PTL_PS_AMP10_LO     6
`define PTL_PS_RSV_HI_RST   3'h3
`define PTL_PS_AMP_RST      3'h3
`define PTL_PS_RSV0_RST     1'h1
`define PTL_TEN_RSV_RST     2'h0

`endif

/* File: logic/ptl_shadow_reg.v */
// One 16-bit register with separate hardware and software reset values.
// Assumes the caller supplies per-bit retain masks for software reset.
`timescale 1ns/1ps

module ptl_shadow_reg #(
	parameter [15:0] HW_RST  = 16'h0000,
	parameter [15:0] SW_KEEP = 16'hffff,
	parameter [15:0] WR_MASK = 16'hffff
) (
	input  wire        clk_sys_i,
	input  wire        rst_i,
	input  wire        soft_rst_i,
	input  wire        wr_i,
	input  wire [15:0] wdata_i,
	output reg  [15:0] value_o
);

	// Hardware reset wins, then software reset, then a write
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			value_o <= HW_RST;
		end else if (soft_rst_i) begin
			value_o <= value_o & SW_KEEP; // Unkept bits fall to zero
		end else if (wr_i) begin
			value_o <= (wdata_i & WR_MASK) | (value_o & ~WR_MASK);
		end
	end

endmodule // ptl_shadow_reg

/* File: logic/ptl_test_loop_ctrl.v */
// Extended test, loopback and power saving control registers of a
// 10/100 PHY, reached over an index port and a data port.
// Assumes single-cycle management strobes synchronous to clk_sys_i.
`timescale 1ns/1ps
`include "ptl_defines.vh"

// How it works
// - Bit 15 of the fast test register enables 100 Mb/s loopback test mode and clears on hardware reset.
// - Fast test bit 4 loops data at the MLT-3 coding stage.
// - Fast test bit 3 loops data past the scrambler and descrambler.
// - Fast test bit 2 loops through carrier detect and link monitor.
// - Fast test bit 1 loops through the far-end-fault generator and detector.
// - Fast test bit 0 loops data at the coding sublayer.
// - The 10 Mb/s pattern selector is bit 5 over bits 1:0 of the ten test register.
// - Selector 001 all-ones 10 MHz, 010 random, 011 link pulses, 100 5 MHz, else normal.
// - Ten test bit 2 picks deep (1) or shallow (0) loop and drives the core mode low bit.
// - Power saving bit 15 is read-only, shows the saving state and resets to one.
// - Power saving bits 11:9 set the 100 Mb/s amplitude and reset to 3.
// - Power saving bits 8:6 are a second amplitude field resetting to 3.
module ptl_test_loop_ctrl (
	input  wire        clk_sys_i,
	input  wire        rst_i,
	input  wire        soft_rst_i,
	input  wire        mgmt_wr_i,
	input  wire        mgmt_rd_i,
	input  wire [4:0]  mgmt_addr_i,
	input  wire [15:0] mgmt_wdata_i,
	input  wire        saving_active_i,
	output reg  [15:0] mgmt_rdata_o,
	output reg         mgmt_rvalid_o,
	output reg         fast_loop_test_enable_o,
	output reg         fast_jitter_waveform_o,
	output reg         fast_overswing_waveform_o,
	output reg         fast_dcd_waveform_o,
	output reg         line_code_loop_o,
	output reg         scrambler_loop_o,
	output reg         carrier_monitor_loop_o,
	output reg         far_fault_loop_o,
	output reg         coding_loop_o,
	output reg         ten_ones_10m_o,
	output reg         ten_random_o,
	output reg         ten_link_pulse_o,
	output reg         ten_sine_5m_o,
	output reg         deep_loop_o,
	output reg         shallow_loop_o,
	output reg         ten_core_mode0_o,
	output reg  [2:0]  amp_fast_o,
	output reg  [2:0]  amp_ten_o
);

	reg  [5:0]  index_q;
	reg         global_saving_state_q;
	wire [15:0] fast_q;
	wire [15:0] ten_q;
	wire [15:0] ps_q;
	wire        data_wr;
	wire        wr_fast;
	wire        wr_ten;
	wire        wr_ps;
	wire [2:0]  ten_sel;
	reg  [15:0] ext_rdata;

	// Decode one extended index against the current index
	function hit;
		input [5:0] idx;
		input [5:0] cur;
		begin
			hit = (idx == cur);
		end
	endfunction

	assign data_wr = mgmt_wr_i && (mgmt_addr_i == `PTL_PORT_DATA);
	assign wr_fast = data_wr && hit(`PTL_IDX_FAST_TEST, index_q);
	assign wr_ten  = data_wr && hit(`PTL_IDX_TEN_TEST, index_q);
	assign wr_ps   = data_wr && hit(`PTL_IDX_POWER_SAVE, index_q);

	// Index port; soft reset clears it as well
	always @(posedge clk_sys_i) begin
		if (rst_i || soft_rst_i) begin
			index_q <= 6'h00;
		end else if (mgmt_wr_i && mgmt_addr_i == `PTL_PORT_ADDR) begin
			index_q <= mgmt_wdata_i[5:0];
		end
	end

	// Fast test: bits 14:8 not writable, loop selects dropped on soft reset
	ptl_shadow_reg #(
		.HW_RST  (16'h0000),
		.SW_KEEP (16'h80e0),
		.WR_MASK (16'h80ff)
	) u_fast (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.soft_rst_i (soft_rst_i),
		.wr_i       (wr_fast),
		.wdata_i    (mgmt_wdata_i),
		.value_o    (fast_q)
	);

	// Ten test: reserved 15:14 keep, 5:0 clear on soft reset
	ptl_shadow_reg #(
		.HW_RST  (16'h0000),
		.SW_KEEP (16'hc000),
		.WR_MASK (16'hc027)
	) u_ten (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.soft_rst_i (soft_rst_i),
		.wr_i       (wr_ten),
		.wdata_i    (mgmt_wdata_i),
		.value_o    (ten_q)
	);

	// Power saving: bit 15 held apart, reserved 5:1 clear on soft reset
	ptl_shadow_reg #(
		.HW_RST  ({1'b0, `PTL_PS_RSV_HI_RST, `PTL_PS_AMP_RST,
			`PTL_PS_AMP_RST, 5'h00, `PTL_PS_RSV0_RST}),
		.SW_KEEP (16'hffc1),
		.WR_MASK (16'h7fff)
	) u_ps (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.soft_rst_i (soft_rst_i),
		.wr_i       (wr_ps),
		.wdata_i    (mgmt_wdata_i),
		.value_o    (ps_q)
	);

	// Saving state is tracked from the core, never from writes
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			global_saving_state_q <= 1'b1;
		end else begin
			global_saving_state_q <= saving_active_i;
		end
	end

	assign ten_sel = {ten_q[`PTL_TT_SEL_HI], ten_q[1:0]};

	// Read mux for the selected extended register
	always @* begin
		case (index_q)
			`PTL_IDX_FAST_TEST:  ext_rdata = fast_q & 16'h80ff;
			`PTL_IDX_TEN_TEST:   ext_rdata = ten_q;
			`PTL_IDX_POWER_SAVE: ext_rdata = {global_saving_state_q,
				ps_q[14:0]};
			default:             ext_rdata = 16'h0000;
		endcase
	end

	// Read answer one cycle after the strobe; other offsets read zero
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			mgmt_rdata_o  <= 16'h0000;
			mgmt_rvalid_o <= 1'b0;
		end else begin
			mgmt_rvalid_o <= mgmt_rd_i;
			if (mgmt_rd_i) begin
				case (mgmt_addr_i)
					`PTL_PORT_ADDR: mgmt_rdata_o <= {10'h000, index_q};
					`PTL_PORT_DATA: mgmt_rdata_o <= ext_rdata;
					default:        mgmt_rdata_o <= 16'h0000;
				endcase
			end
		end
	end

	// Registered control outputs; loop selects follow their bits whether or not test mode is enabled
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			fast_loop_test_enable_o   <= 1'b0;
			fast_jitter_waveform_o    <= 1'b0;
			fast_overswing_waveform_o <= 1'b0;
			fast_dcd_waveform_o       <= 1'b0;
			line_code_loop_o          <= 1'b0;
			scrambler_loop_o          <= 1'b0;
			carrier_monitor_loop_o    <= 1'b0;
			far_fault_loop_o          <= 1'b0;
			coding_loop_o             <= 1'b0;
			ten_ones_10m_o            <= 1'b0;
			ten_random_o              <= 1'b0;
			ten_link_pulse_o          <= 1'b0;
			ten_sine_5m_o             <= 1'b0;
			deep_loop_o               <= 1'b0;
			shallow_loop_o            <= 1'b1;
			ten_core_mode0_o          <= 1'b0;
			amp_fast_o                <= `PTL_PS_AMP_RST;
			amp_ten_o                 <= `PTL_PS_AMP_RST;
		end else begin
			fast_loop_test_enable_o   <= fast_q[`PTL_FT_ENABLE];
			fast_jitter_waveform_o    <= fast_q[`PTL_FT_JITTER];
			fast_overswing_waveform_o <= fast_q[`PTL_FT_OVERSWING];
			fast_dcd_waveform_o       <= fast_q[`PTL_FT_DCD];
			line_code_loop_o          <= fast_q[`PTL_FT_LINE_CODE];
			scrambler_loop_o          <= fast_q[`PTL_FT_SCRAMBLER];
			carrier_monitor_loop_o    <= fast_q[`PTL_FT_CARRIER_MON];
			far_fault_loop_o          <= fast_q[`PTL_FT_FAR_FAULT];
			coding_loop_o             <= fast_q[`PTL_FT_CODING];
			ten_ones_10m_o   <= (ten_sel == `PTL_PAT_ONES_10M);
			ten_random_o     <= (ten_sel == `PTL_PAT_RANDOM);
			ten_link_pulse_o <= (ten_sel == `PTL_PAT_LINK_PULSE);
			ten_sine_5m_o    <= (ten_sel == `PTL_PAT_SINE_5M);
			deep_loop_o      <= ten_q[`PTL_TT_DEPTH];
			shallow_loop_o   <= ~ten_q[`PTL_TT_DEPTH];
			ten_core_mode0_o <= ten_q[`PTL_TT_DEPTH];
			amp_fast_o <= ps_q[`PTL_PS_AMP100_LO +: 3];
			amp_ten_o  <= ps_q[`PTL_PS_AMP10_LO +: 3];
		end
	end

endmodule // ptl_test_loop_ctrl

/* File: dv/ptl_tlc_monitor.sv */
// Port checks for the test, loopback and power saving control block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module ptl_tlc_monitor (
	input wire        clk_sys_i, rst_i, soft_rst_i, mgmt_wr_i, mgmt_rd_i,
	input wire [15:0] mgmt_rdata_o,
	input wire        mgmt_rvalid_o, fast_loop_test_enable_o,
	input wire        line_code_loop_o, coding_loop_o, ten_sine_5m_o,
	input wire        deep_loop_o, shallow_loop_o, ten_core_mode0_o,
	input wire [2:0]  amp_fast_o, amp_ten_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// Read answer comes one cycle after the strobe and only then
	a_read_answer: assert property (mgmt_rd_i |=> mgmt_rvalid_o)
		else $error("read strobe not answered");
	a_answer_cause: assert property (mgmt_rvalid_o |-> $past(mgmt_rd_i))
		else $error("answer without read strobe");
	a_rdata_hold: assert property (!mgmt_rvalid_o |-> $stable(mgmt_rdata_o))
		else $error("read data moved without answer");
	// Loop depth outputs are one bit seen three ways
	a_depth_pair: assert property (shallow_loop_o != deep_loop_o)
		else $error("shallow and deep loop agree");
	a_core_mode: assert property (ten_core_mode0_o == deep_loop_o)
		else $error("core mode bit differs from depth");
	// Soft reset clears selects two edges on, keeps enable and amplitude
	a_soft_clear: assert property (soft_rst_i |-> ##2
		!(line_code_loop_o | coding_loop_o | deep_loop_o | ten_sine_5m_o))
		else $error("loop select survived soft reset");
	a_soft_keeps: assert property (!mgmt_wr_i [*2] ##1
		(soft_rst_i && !mgmt_wr_i) |-> ##2 (amp_fast_o == $past(amp_fast_o, 3)
		&& fast_loop_test_enable_o == $past(fast_loop_test_enable_o, 3)))
		else $error("soft reset changed a kept field");
	a_hw_defaults: assert property ($fell(rst_i) |->
		amp_fast_o == 3'h3 && amp_ten_o == 3'h3 && !fast_loop_test_enable_o)
		else $error("wrong value after hardware reset");
	c_read: cover property (mgmt_rvalid_o);
	c_deep: cover property (deep_loop_o);
	c_soft: cover property (soft_rst_i);
endmodule // ptl_tlc_monitor

bind ptl_test_loop_ctrl ptl_tlc_monitor mon (.*);

/* File: dv/ptl_host_model.sv */
// Management host: reaches extended registers via index and data ports.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/1ps
module ptl_host_model (
	input  wire        clk_sys_i,
	input  wire        rvalid_i,
	input  wire [15:0] rdata_i,
	output reg         wr_o = 1'b0,
	output reg         rd_o = 1'b0,
	output reg  [4:0]  addr_o = 5'h00,
	output reg  [15:0] wdata_o = 16'h0000
);
	// One write; bus inverted after so stale data never looks held
	task put(input [4:0] a, input [15:0] d);
	begin
		@(posedge clk_sys_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_sys_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	end
	endtask
	// Index port always written before the data port
	task wreg(input [5:0] i, input [15:0] d);
	begin
		put(5'h1d, {10'h000, i});
		put(5'h1e, d);
	end
	endtask
	// Index port written first, then the data port read
	task rreg(input [5:0] i, output [15:0] q, output ok);
	begin
		put(5'h1d, {10'h000, i});
		rport(5'h1e, q, ok);
	end
	endtask
	// One read of a port; the answer is awaited a bounded time
	task rport(input [4:0] a, output [15:0] q, output ok);
	integer n;
	begin
		@(posedge clk_sys_i);
		rd_o <= 1'b1;
		addr_o <= a;
		ok = 1'b0;
		q = 16'h0000;
		for (n = 0; n < 4 && !ok; n = n + 1) begin
			@(posedge clk_sys_i);
			rd_o <= 1'b0;
			#1;
			if (rvalid_i === 1'b1) begin
				ok = 1'b1;
				q = rdata_i;
			end
		end
	end
	endtask
endmodule // ptl_host_model

/* File: dv/tb_ptl_test_loop_ctrl.sv */
// Self-checking bench for the test and loopback control registers.
// Assumes the host model drives all management strobes.
`timescale 1ns/1ps
module tb_ptl_test_loop_ctrl;
	reg         clk = 1'b0, rst = 1'b1, srst = 1'b0, sav = 1'b1, ok;
	wire        wr, rd, rv;
	wire [4:0]  addr;
	wire [15:0] wd, rdat;
	wire [8:0]  fo;
	wire [6:0]  to;
	wire [2:0]  af, at;
	integer     failures = 0, checks = 0, i;
	reg  [15:0] q, d;

	initial forever #10 clk = ~clk;

	ptl_test_loop_ctrl dut (.clk_sys_i(clk), .rst_i(rst), .soft_rst_i(srst),
		.mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_addr_i(addr), .mgmt_wdata_i(wd),
		.saving_active_i(sav), .mgmt_rdata_o(rdat), .mgmt_rvalid_o(rv),
		.fast_loop_test_enable_o(fo[8]), .fast_jitter_waveform_o(fo[7]),
		.fast_overswing_waveform_o(fo[6]), .fast_dcd_waveform_o(fo[5]),
		.line_code_loop_o(fo[4]), .scrambler_loop_o(fo[3]),
		.carrier_monitor_loop_o(fo[2]), .far_fault_loop_o(fo[1]),
		.coding_loop_o(fo[0]), .ten_ones_10m_o(to[6]), .ten_random_o(to[5]),
		.ten_link_pulse_o(to[4]), .ten_sine_5m_o(to[3]), .deep_loop_o(to[2]),
		.shallow_loop_o(to[1]), .ten_core_mode0_o(to[0]),
		.amp_fast_o(af), .amp_ten_o(at));
	ptl_host_model host (.clk_sys_i(clk), .rvalid_i(rv), .rdata_i(rdat),
		.wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd));

	task chk(input [15:0] got, input [15:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task end_sim;
	begin
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	// Bounded read; a missing answer ends the run
	task rd_chk(input [5:0] idx, input [15:0] exp);
	begin
		host.rreg(idx, q, ok);
		if (!ok) begin
			failures = failures + 1;
			end_sim;
		end
		chk(q, exp);
	end
	endtask
	// Index port read straight; an unanswered read is a mismatch
	task idx_chk(input [15:0] exp);
	begin
		host.rport(5'h1d, q, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(q, exp);
	end
	endtask
	// Controls lag the register by one edge, so let that edge pass
	task wr_set(input [5:0] idx, input [15:0] v);
	begin
		host.wreg(idx, v);
		@(posedge clk);
		#1;
	end
	endtask
	task t_reset;
	begin
		chk({7'h00, fo}, 16'h0000);
		chk({9'h000, to}, 16'h0002);
		chk({10'h000, af, at}, 16'h001b);
		rd_chk(6'h10, 16'h0000);
		rd_chk(6'h12, 16'h0000);
		rd_chk(6'h29, 16'hb6c1);
		$display("reset test done");
	end
	endtask
	task t_fast;
	begin
		for (i = 0; i < 16; i = i + 1) begin
			d = 16'h0001 << i;
			wr_set(6'h10, d);
			chk({7'h00, fo}, {7'h00, d[15], d[7:0]});
			rd_chk(6'h10, d & 16'h80ff);
		end
		$display("fast test done");
	end
	endtask
	// Every selector code with both depths, reserved bits set
	task t_ten;
	begin
		for (i = 0; i < 16; i = i + 1) begin
			d = {10'h000, i[3], 2'b00, i[0], i[2:1]};
			wr_set(6'h12, d | 16'hffd8);
			chk({9'h000, to}, {9'h000, i[3:1] == 3'h1, i[3:1] == 3'h2,
				i[3:1] == 3'h3, i[3:1] == 3'h4, i[0], !i[0], i[0]});
			rd_chk(6'h12, d | 16'hc000);
		end
		$display("ten test done");
	end
	endtask
	task t_ps;
	begin
		@(posedge clk) sav <= 1'b0;
		wr_set(6'h29, 16'h8a81);
		chk({10'h000, af, at}, 16'h002a);
		rd_chk(6'h29, 16'h0a81);
		@(posedge clk) sav <= 1'b1;
		rd_chk(6'h29, 16'h8a81);
		wr_set(6'h05, 16'hffff);
		rd_chk(6'h05, 16'h0000);
		idx_chk(16'h0005);
		$display("power test done");
	end
	endtask
	task t_soft;
	begin
		wr_set(6'h10, 16'h80ff);
		wr_set(6'h12, 16'h0027);
		@(posedge clk) srst <= 1'b1;
		@(posedge clk) srst <= 1'b0;
		@(posedge clk) #1;
		chk({fo, to}, 16'hf002);
		chk({10'h000, af, at}, 16'h002a);
		idx_chk(16'h0000);
		rd_chk(6'h10, 16'h80e0);
		rd_chk(6'h12, 16'h0000);
		$display("soft reset test done");
	end
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_fast;
		t_ten;
		t_ps;
		t_soft;
		end_sim;
	end
endmodule // tb_ptl_test_loop_ctrl
